/* File: rtl/adc_ctrl_pkg.sv */
// Constants, register map and state codes for the conversion controller
package adc_ctrl_pkg;
	// ------------------------------------------------------------
	// Bus widths
	// ------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int ADDR_W = 3;
	localparam int RES_W = 12;
	localparam int CHAN_W = 5;
	localparam int CNT_W = 9;
	localparam int CAL_W = 12;
	// ------------------------------------------------------------
	// Register offsets (word index on the plain port)
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] OFF_DIV = 3'h1;
	localparam logic [ADDR_W-1:0] OFF_SAMPLE = 3'h2;
	localparam logic [ADDR_W-1:0] OFF_CHAN = 3'h3;
	localparam logic [ADDR_W-1:0] OFF_CMD = 3'h4;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 3'h5;
	localparam logic [ADDR_W-1:0] OFF_RESULT = 3'h6;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int MODE_W = 4;
	localparam int MODE_CAL_SKIP = 3;
	localparam int MODE_KEEP_ON = 2;
	localparam int CTRL_PD_BIT = 4;
	localparam int CMD_START_BIT = 0;
	localparam int CMD_CAL_BIT = 1;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_CAL_BIT = 1;
	localparam int ST_ERR_BIT = 2;
	localparam int ST_VALID_BIT = 3;
	// ------------------------------------------------------------
	// Resolution codes in the two low mode bits
	// ------------------------------------------------------------
	localparam logic [1:0] RES_10 = 2'h0;
	localparam logic [1:0] RES_12 = 2'h1;
	localparam logic [1:0] RES_8 = 2'h2;
	localparam logic [1:0] RES_BAD = 2'h3;
	localparam logic [CNT_W-1:0] BITS_12 = 9'h00c;
	localparam logic [CNT_W-1:0] BITS_10 = 9'h00a;
	localparam logic [CNT_W-1:0] BITS_8 = 9'h008;
	// ------------------------------------------------------------
	// Timing counts in conversion-clock periods
	// ------------------------------------------------------------
	localparam logic [CNT_W-1:0] SAMPLE_EXTRA = 9'h002;
	localparam logic [CNT_W-1:0] POSTCAL_TICKS = 9'h002;
	localparam logic [CAL_W-1:0] CAL_TICKS = 12'hf00;
	localparam int DIV_FACTOR = 4;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
	localparam logic [7:0] DIV_RST = 8'h01;
	localparam logic [7:0] SAMPLE_RST = 8'h03;
	localparam logic [CHAN_W-1:0] CHAN_RST = 5'h00;
	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SYNC_IN = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_DISTRIB = 3'b011,
		ST_POSTCAL = 3'b100,
		ST_SYNC_OUT = 3'b101
	} conv_state_e;
endpackage

/* File: rtl/adc_conversion_control.sv */
// Conversion sequencer, clock divider and register port for the on-chip SAR converter
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// R1 - Low mode bits choose 10, 12 or 8 bits
// R2 - Every result appears on a 12-bit word
// R3 - 8-bit result sits high, four zeros below
// R4 - 10-bit result sits high, two zeros below
// R5 - Mode bit 3 low adds two-tick post-calibration
// R6 - Mode bit 2 low powers down after conversion
// R7 - Conversion clock period is 4*(1+divider)
// R8 - Sampling lasts two plus sample-count ticks
// R9 - Distribution takes one tick per bit
// R10 - Sync, sample, distribute, calibrate, sync in order
// R11 - Full calibration takes 3840 ticks regardless
// R12 - Five-bit binary channel number 0 to 31
// R13 - Power-down disables comparators only
// R14 - One-cycle done pulse on new result
module adc_conversion_control (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic [adc_ctrl_pkg::ADDR_W-1:0] regAddr,
	input wire logic [adc_ctrl_pkg::DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic compBit,
	output var logic [adc_ctrl_pkg::DATA_W-1:0] regRdata,
	output var logic [adc_ctrl_pkg::RES_W-1:0] resultWord,
	output var logic resultDone,
	output var logic convClk,
	output var logic sampleHold,
	output var logic compPowerDown,
	output var logic [adc_ctrl_pkg::CHAN_W-1:0] channelSel,
	output var logic calRunning
);
	import adc_ctrl_pkg::*;

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic [1:0] rstSync_r; // Two-stage release chain
	logic rstSync_n; // Synchronised reset for the whole block

	// Assert at once, release on the clock to avoid recovery hazards
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync_r <= 2'h0;
		end else begin
			rstSync_r <= {rstSync_r[0], 1'b1};
		end
	end
	assign rstSync_n = rstSync_r[1];

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	logic [MODE_W-1:0] mode_r; // Mode bits for the next start
	logic pdSw_r; // Software comparator power-down
	logic [7:0] clkDiv_r; // Clock divider setting
	logic [7:0] sampleCnt_r; // Sample count setting
	logic [CHAN_W-1:0] chanReg_r; // Channel for the next start
	logic wrCtrl; // Write to the control word
	logic wrCmd; // Write to the command word
	logic startReq; // Software asks for a conversion
	logic calReq; // Software asks for full calibration

	assign wrCtrl = regWr && (regAddr == OFF_CTRL);
	assign wrCmd = regWr && (regAddr == OFF_CMD);
	assign startReq = wrCmd && regWdata[CMD_START_BIT];
	assign calReq = wrCmd && regWdata[CMD_CAL_BIT];

	// Setting registers; they may change at any time; only mode and channel are latched at start
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			mode_r <= MODE_RST;
			pdSw_r <= 1'b0;
			clkDiv_r <= DIV_RST;
			sampleCnt_r <= SAMPLE_RST;
			chanReg_r <= CHAN_RST;
		end else if (clkEn && regWr) begin
			if (regAddr == OFF_CTRL) begin
				mode_r <= regWdata[MODE_W-1:0];
				pdSw_r <= regWdata[CTRL_PD_BIT];
			end else if (regAddr == OFF_DIV) begin
				clkDiv_r <= regWdata[7:0];
			end else if (regAddr == OFF_SAMPLE) begin
				sampleCnt_r <= regWdata[7:0];
			end else if (regAddr == OFF_CHAN) begin
				chanReg_r <= regWdata[CHAN_W-1:0]; // R12
			end
		end
	end

	// ------------------------------------------------------------
	// Conversion clock divider
	// ------------------------------------------------------------
	logic [CNT_W-1:0] halfCnt_r; // System cycles in this half period
	logic [CNT_W-1:0] halfMax; // Last count of a half period
	logic convTick; // Rising edge of the conversion clock

	// Half period is 2*(1+div) cycles, so a full one is 4*(1+div)
	assign halfMax = {clkDiv_r, 1'b1}; // R7
	assign convTick = (halfCnt_r >= halfMax) && !convClk;

	// Free-running divider; >= keeps it sane when the divider shrinks
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			halfCnt_r <= '0;
			convClk <= 1'b0;
		end else if (clkEn) begin
			if (halfCnt_r >= halfMax) begin
				halfCnt_r <= '0;
				convClk <= !convClk; // R7
			end else begin
				halfCnt_r <= halfCnt_r + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------
	conv_state_e st_r; // Current phase
	conv_state_e stNxt; // Next phase
	logic [CNT_W-1:0] cnt_r; // Ticks spent in a counted phase
	logic [MODE_W-1:0] modeL_r; // Mode latched at start
	logic [CNT_W-1:0] bitsN; // Bits for the latched resolution
	logic [CNT_W-1:0] sampleLen; // Sampling length in ticks
	logic [CNT_W-1:0] phaseLen; // Ticks in the phase in progress
	logic lastTick; // Final tick of a counted phase
	logic startOk; // Start accepted this cycle
	logic [RES_W-1:0] sar_r; // Bits gathered during distribution

	// Resolution decode from the latched mode
	always_comb begin
		case (modeL_r[1:0])
			RES_12: bitsN = BITS_12; // R1
			RES_8: bitsN = BITS_8; // R1
			default: bitsN = BITS_10; // R1
		endcase
	end

	assign sampleLen = SAMPLE_EXTRA + {1'b0, sampleCnt_r}; // R8
	assign lastTick = convTick && (cnt_r == phaseLen - 1'b1);
	// A start is refused while busy or when the resolution code is unused
	assign startOk = startReq && (st_r == ST_IDLE) && (mode_r[1:0] != RES_BAD);

	// Length of the phase in progress; a process keeps it sensitive to the state
	always_comb begin
		phaseLen = POSTCAL_TICKS;
		if (st_r == ST_SAMPLE) begin
			phaseLen = sampleLen;
		end else if (st_r == ST_DISTRIB) begin
			phaseLen = bitsN;
		end
	end

	// Phase order; the sync steps are a single system cycle each
	always_comb begin
		stNxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (startOk) begin
					stNxt = ST_SYNC_IN; // R10
				end
			end
			ST_SYNC_IN: begin
				stNxt = ST_SAMPLE; // R10
			end
			ST_SAMPLE: begin
				if (lastTick) begin
					stNxt = ST_DISTRIB; // R8
				end
			end
			ST_DISTRIB: begin
				if (lastTick) begin
					// Calibration only when the skip bit is clear
					stNxt = modeL_r[MODE_CAL_SKIP] ? ST_SYNC_OUT : ST_POSTCAL; // R5
				end
			end
			ST_POSTCAL: begin
				if (lastTick) begin
					stNxt = ST_SYNC_OUT; // R5
				end
			end
			ST_SYNC_OUT: begin
				stNxt = ST_IDLE; // R10
			end
			default: begin
				stNxt = ST_IDLE;
			end
		endcase
	end

	// State and tick counter; counter restarts at every phase change
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			st_r <= ST_IDLE;
			cnt_r <= '0;
		end else if (clkEn) begin
			st_r <= stNxt;
			if (stNxt != st_r) begin
				cnt_r <= '0;
			end else if (convTick) begin
				cnt_r <= cnt_r + 1'b1; // R9
			end
		end
	end

	// Latch mode and channel so mid-conversion writes cannot disturb it
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			modeL_r <= MODE_RST;
			channelSel <= CHAN_RST;
		end else if (clkEn && startOk) begin
			modeL_r <= mode_r;
			channelSel <= chanReg_r; // R12
		end
	end

	// One comparator decision per tick, MSB first
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			sar_r <= '0;
		end else if (clkEn) begin
			if (st_r == ST_SYNC_IN) begin
				sar_r <= '0;
			end else if (st_r == ST_DISTRIB && convTick) begin
				sar_r <= {sar_r[RES_W-2:0], compBit}; // R9
			end
		end
	end

	// ------------------------------------------------------------
	// Result word and completion
	// ------------------------------------------------------------
	logic valid_r; // Unread result waiting
	logic err_r; // Refused start with unused resolution

	// Align to the top of the word; low bits zero-filled at lower resolution
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			resultWord <= '0;
			resultDone <= 1'b0;
		end else if (clkEn) begin
			resultDone <= (st_r == ST_SYNC_OUT); // R14
			if (st_r == ST_SYNC_OUT) begin
				if (modeL_r[1:0] == RES_12) begin
					resultWord <= sar_r; // R2
				end else if (modeL_r[1:0] == RES_8) begin
					resultWord <= {sar_r[7:0], 4'h0}; // R3
				end else begin
					resultWord <= {sar_r[9:0], 2'h0}; // R4
				end
			end
		end
	end

	// Sticky flags; a new set beats a clear in the same cycle
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			valid_r <= 1'b0;
			err_r <= 1'b0;
		end else if (clkEn) begin
			if (st_r == ST_SYNC_OUT) begin
				valid_r <= 1'b1;
			end else if (regRd && regAddr == OFF_RESULT) begin
				valid_r <= 1'b0;
			end
			if (startReq && st_r == ST_IDLE && mode_r[1:0] == RES_BAD) begin
				err_r <= 1'b1; // R1
			end else if (wrCtrl) begin
				err_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Power-down and sampling outputs
	// ------------------------------------------------------------
	logic pdAuto_r; // Converter idle after a conversion

	// Only the comparators are switched; the logic here keeps running
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			pdAuto_r <= 1'b0;
			compPowerDown <= 1'b0;
			sampleHold <= 1'b0;
		end else if (clkEn) begin
			if (startOk) begin
				pdAuto_r <= 1'b0;
			end else if (st_r == ST_SYNC_OUT) begin
				pdAuto_r <= !modeL_r[MODE_KEEP_ON]; // R6
			end
			compPowerDown <= pdSw_r || pdAuto_r; // R13
			sampleHold <= (stNxt == ST_SAMPLE);
		end
	end

	// ------------------------------------------------------------
	// Full calibration
	// ------------------------------------------------------------
	logic [CAL_W-1:0] calCnt_r; // Ticks of calibration done

	// Runs in the background; conversions do not stretch or cut it
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			calRunning <= 1'b0;
			calCnt_r <= '0;
		end else if (clkEn) begin
			if (!calRunning && calReq) begin
				calRunning <= 1'b1;
				calCnt_r <= '0;
			end else if (calRunning && convTick) begin
				if (calCnt_r == CAL_TICKS - 1'b1) begin
					calRunning <= 1'b0; // R11
				end
				calCnt_r <= calCnt_r + 1'b1; // R11
			end
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	// Data valid only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			regRdata <= '0;
		end else if (clkEn) begin
			regRdata <= '0;
			if (regRd) begin
				if (regAddr == OFF_CTRL) begin
					regRdata <= {11'h000, pdSw_r, mode_r};
				end else if (regAddr == OFF_DIV) begin
					regRdata <= {8'h00, clkDiv_r};
				end else if (regAddr == OFF_SAMPLE) begin
					regRdata <= {8'h00, sampleCnt_r};
				end else if (regAddr == OFF_CHAN) begin
					regRdata <= {11'h000, chanReg_r};
				end else if (regAddr == OFF_STATUS) begin
					regRdata <= {12'h000, valid_r, err_r, calRunning, st_r != ST_IDLE};
				end else if (regAddr == OFF_RESULT) begin
					regRdata <= {4'h0, resultWord};
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [CNT_W+1:0] sinceTick_r; // Cycles since last tick
	logic tickSeen_r; // First tick seen; periods after it are whole
	logic divWr_r; // Divider written since last tick

	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			sinceTick_r <= '0;
			tickSeen_r <= 1'b0;
			divWr_r <= 1'b0;
		end else if (clkEn) begin
			sinceTick_r <= convTick ? '0 : sinceTick_r + 1'b1;
			if (convTick) begin
				tickSeen_r <= 1'b1;
			end
			divWr_r <= (regWr && regAddr == OFF_DIV) || (divWr_r && !convTick);
		end
	end

	a_res_width: assert property (@(posedge ref_clk) disable iff (!rstSync_n) // R1
		clkEn && st_r == ST_DISTRIB && stNxt != ST_DISTRIB |-> cnt_r + 1'b1 == (modeL_r[1:0] == RES_12 ? BITS_12 :
		modeL_r[1:0] == RES_8 ? BITS_8 : BITS_10))
		else $error("resolution does not follow mode");
	a_eight_low: assert property (@(posedge ref_clk) disable iff (!rstSync_n) // R3
		resultDone && modeL_r[1:0] == RES_8 |-> resultWord[3:0] == 4'h0)
		else $error("8-bit result low nibble not zero");
	a_ten_low: assert property (@(posedge ref_clk) disable iff (!rstSync_n) // R4
		resultDone && modeL_r[1:0] == RES_10 |-> resultWord[1:0] == 2'h0 && resultWord[11:2] == sar_r[9:0])
		else $error("10-bit result misaligned");
	a_cal_skip: assert property (@(posedge ref_clk) disable iff (!rstSync_n) // R5
		st_r == ST_POSTCAL |-> !modeL_r[MODE_CAL_SKIP])
		else $error("post-calibration ran while skipped");
	a_pd_after: assert property (@(posedge ref_clk) disable iff (!rstSync_n) // R6
		resultDone && clkEn && !modeL_r[MODE_KEEP_ON] |=> compPowerDown)
		else $error("no power-down after conversion");
	a_div_period: assert property (@(posedge ref_clk) disable iff (!rstSync_n) // R7
		clkEn && convTick && tickSeen_r && !divWr_r |-> sinceTick_r == DIV_FACTOR * (clkDiv_r + 1) - 1)
		else $error("conversion clock period wrong");
	a_sample_len: assert property (@(posedge ref_clk) disable iff (!rstSync_n) // R8
		clkEn && st_r == ST_SAMPLE && stNxt == ST_DISTRIB |-> cnt_r + 1'b1 == sampleLen)
		else $error("sampling length wrong");
	a_distrib_len: assert property (@(posedge ref_clk) disable iff (!rstSync_n) // R9
		clkEn && st_r == ST_DISTRIB && stNxt != ST_DISTRIB |-> cnt_r + 1'b1 == bitsN)
		else $error("distribution length wrong");
	a_sync_order: assert property (@(posedge ref_clk) disable iff (!rstSync_n) // R10
		clkEn && st_r == ST_SYNC_IN |=> st_r == ST_SAMPLE)
		else $error("input sync not one cycle");
	a_cal_total: assert property (@(posedge ref_clk) disable iff (!rstSync_n) // R11
		$fell(calRunning) |-> calCnt_r == CAL_TICKS)
		else $error("calibration length wrong");
	a_comp_only: assert property (@(posedge ref_clk) disable iff (!rstSync_n) // R13
		sampleHold && !pdSw_r && !$past(pdSw_r) |-> !compPowerDown)
		else $error("comparators off while sampling");
	a_done_pulse: assert property (@(posedge ref_clk) disable iff (!rstSync_n) // R14
		resultDone && clkEn |=> !resultDone)
		else $error("done pulse longer than a cycle");
endmodule
`default_nettype wire

/* File: verification/comp_model.sv */
// Comparator-side model that feeds one decision bit per conversion tick
`timescale 1ns/100ps
`default_nettype none
module comp_model
import adc_ctrl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic convClk,
	input wire logic sampleHold,
	input wire logic [RES_W-1:0] pattern,
	input wire logic [3:0] nBits,
	output var logic compBit
);
	// ------------------------------------------------------------
	// Frame tracking
	// ------------------------------------------------------------
	logic prevClk; // Conversion clock one cycle ago
	logic prevHold; // Sample phase one cycle ago
	logic active; // Inside the distribution frame
	logic skipFirst; // First falling edge after the frame opens keeps the MSB
	logic [3:0] idx; // Bit being presented
	// Bits change on falling conversion-clock edges so they are settled at each rising tick
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prevClk <= 1'b0;
			prevHold <= 1'b0;
			active <= 1'b0;
			skipFirst <= 1'b0;
			idx <= 4'h0;
			compBit <= 1'b0;
		end else begin
			prevClk <= convClk;
			prevHold <= sampleHold;
			if (prevHold && !sampleHold) begin
				// Frame opens with the most significant bit
				active <= 1'b1;
				skipFirst <= 1'b1;
				idx <= 4'h0;
				compBit <= pattern[RES_W-1];
			end else if (active && prevClk && !convClk) begin
				if (skipFirst) begin
					skipFirst <= 1'b0;
				end else if (idx + 4'h1 < nBits) begin
					// One new bit per tick, MSB first
					idx <= idx + 4'h1;
					compBit <= pattern[RES_W-2-idx];
				end else begin
					// Frame over: stale data would hide a late sample, so invert it
					active <= 1'b0;
					compBit <= ~compBit;
				end
			end else if (!active) begin
				// Outside frames the line carries nothing useful
				compBit <= ~compBit;
			end
		end
	end
endmodule
`default_nettype wire

/* File: verification/adc_conversion_control_tb.sv */
// Self-checking testbench for the conversion controller
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_control_tb;
	import adc_ctrl_pkg::*;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	localparam int LIMIT = 60000; // Whole run needs about 20000 cycles
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clkEn = 1'b1; // Held running except for one frozen write in the power-down test
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWdata = '0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic compBit;
	logic [DATA_W-1:0] regRdata;
	logic [RES_W-1:0] resultWord;
	logic resultDone, convClk, sampleHold, compPowerDown, calRunning;
	logic [CHAN_W-1:0] channelSel;
	logic [3:0] watch; // Levels the wait task follows: 0 clock, 1 hold, 2 done, 3 calibration
	assign watch = {calRunning, resultDone, sampleHold, convClk};
	logic [RES_W-1:0] pattern = '0; // Value the comparator model sends
	logic [3:0] nBits = 4'h8; // Bits in the current frame
	int nErrors = 0;
	int totalChecks = 0;
	int cycles = 0;
	always #5 ref_clk = ~ref_clk;
	adc_conversion_control u_adc_conversion_control (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .compBit(compBit),
		.regRdata(regRdata), .resultWord(resultWord), .resultDone(resultDone), .convClk(convClk),
		.sampleHold(sampleHold), .compPowerDown(compPowerDown), .channelSel(channelSel),
		.calRunning(calRunning));
	comp_model u_comp_model (.ref_clk(ref_clk), .rst_n(rst_n), .convClk(convClk), .sampleHold(sampleHold),
		.pattern(pattern), .nBits(nBits), .compBit(compBit));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic completeRun;
		$display("Checks %0d, errors %0d", totalChecks, nErrors);
		if (nErrors == 0 && totalChecks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			nErrors = nErrors + 1;
			completeRun();
		end
	end
	task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		totalChecks = totalChecks + 1;
		if (seen !== exp) begin
			nErrors = nErrors + 1;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	// One-cycle read strobe; data taken in the following cycle only
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
	// Bounded wait for a level, counting cycles into n
	task automatic waitLvl(input int i, input logic v, inout int n);
		int k;
		k = 0;
		while (watch[i] !== v && k < 20000) begin
			@(posedge ref_clk);
			#1 n++;
			k++;
		end
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic chkReset;
		logic [DATA_W-1:0] d;
		chk(compPowerDown, 1'b0);
		wr(OFF_STATUS, 16'hffff);
		for (int a = 0; a < 8; a++) begin
			rd(a[ADDR_W-1:0], d);
			chk(d, (a == 1) ? 16'h0001 : (a == 2) ? 16'h0003 : 16'h0000);
		end
	endtask
	task automatic clkPeriod(input logic [7:0] div);
		int n;
		wr(OFF_DIV, {8'h00, div});
		n = 0;
		waitLvl(0, 1'b1, n);
		waitLvl(0, 1'b0, n);
		waitLvl(0, 1'b1, n);
		n = 0;
		waitLvl(0, 1'b0, n);
		waitLvl(0, 1'b1, n);
		chk(16'(n), 16'(4 * (1 + div)));
	endtask
	task automatic badMode;
		logic [DATA_W-1:0] d;
		wr(OFF_CTRL, {12'h000, 2'b01, RES_BAD});
		wr(OFF_CMD, 16'h0001);
		rd(OFF_STATUS, d);
		chk(d, 16'h0004);
		chk(sampleHold, 1'b0);
		wr(OFF_CTRL, 16'h0004);
		rd(OFF_STATUS, d);
		chk(d, 16'h0000);
	endtask
	task automatic swPowerDown;
		// A write while the enable is low must leave the power-down bit alone
		@(posedge ref_clk);
		clkEn <= 1'b0;
		wr(OFF_CTRL, 16'h0014);
		@(posedge ref_clk);
		clkEn <= 1'b1;
		@(posedge ref_clk);
		#1 chk(compPowerDown, 1'b0);
		wr(OFF_CTRL, 16'h0014);
		@(posedge ref_clk);
		#1 chk(compPowerDown, 1'b1);
		wr(OFF_CTRL, 16'h0004);
		@(posedge ref_clk);
		#1 chk(compPowerDown, 1'b0);
	endtask
	// Full conversion with phase timing, alignment and status checks
	task automatic conv(input logic [3:0] mode, input logic [7:0] div, input logic [7:0] smp,
		input logic [CHAN_W-1:0] chan, input logic [RES_W-1:0] pat);
		int p, nb, pc, t;
		logic [RES_W-1:0] exp;
		logic [DATA_W-1:0] d;
		p = 4 * (1 + div);
		nb = (mode[1:0] == RES_12) ? 12 : (mode[1:0] == RES_8) ? 8 : 10;
		pc = mode[MODE_CAL_SKIP] ? 0 : 2;
		exp = pat & (12'hfff << (12 - nb));
		pattern <= pat;
		nBits <= nb[3:0];
		wr(OFF_DIV, {8'h00, div});
		wr(OFF_SAMPLE, {8'h00, smp});
		wr(OFF_CHAN, {11'h000, chan});
		wr(OFF_CTRL, {12'h000, mode});
		wr(OFF_CMD, 16'h0001);
		t = 0;
		waitLvl(1, 1'b1, t);
		chk(16'(t), 16'h0001);
		t = 0;
		waitLvl(1, 1'b0, t);
		chk(16'(t >= (1 + smp) * p && t <= (2 + smp) * p + 1), 16'h0001);
		t = 0;
		waitLvl(2, 1'b1, t);
		chk(16'(t >= (nb + pc) * p && t <= (nb + pc) * p + 2), 16'h0001);
		chk(resultWord, exp);
		chk(channelSel, chan);
		@(posedge ref_clk);
		#1 chk(resultDone, 1'b0);
		repeat (3) @(posedge ref_clk);
		#1 chk(compPowerDown, !mode[MODE_KEEP_ON]);
		rd(OFF_STATUS, d);
		chk(d & 16'h000d, 16'h0008);
		rd(OFF_RESULT, d);
		chk(d, {4'h0, exp});
		rd(OFF_STATUS, d);
		chk(d & 16'h000d, 16'h0000);
	endtask
	// Full calibration overlapped with a conversion and a refused restart
	task automatic calib;
		int s, t;
		wr(OFF_DIV, 16'h0000);
		wr(OFF_CMD, 16'h0002);
		s = cycles;
		#1 chk(calRunning, 1'b1);
		conv(4'b1110, 8'h00, 8'h00, 5'h09, 12'h6b2);
		wr(OFF_CMD, 16'h0002);
		t = 0;
		waitLvl(3, 1'b0, t);
		chk(16'(cycles - s >= 3839 * 4 && cycles - s <= 3840 * 4 + 2), 16'h0001);
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chkReset();
		clkPeriod(8'h00);
		clkPeriod(8'h05);
		clkPeriod(8'hff);
		badMode();
		swPowerDown();
		conv(4'b1110, 8'h00, 8'h00, 5'h1f, 12'ha5f);
		conv(4'b0000, 8'h01, 8'h03, 5'h00, 12'h5a7);
		conv(4'b0101, 8'h02, 8'h01, 5'h15, 12'hc3a);
		conv(4'b1001, 8'h00, 8'hff, 5'h0e, 12'h3c5);
		calib();
		completeRun();
	end
endmodule
`default_nettype wire
